// file: shared/ssc_regs.svh
// constants for the system select code control block
`ifndef SSC_REGS_SVH
`define SSC_REGS_SVH
`define SSC_SC_MASK      3'h0
`define SSC_SC_STATUS    3'h1
`define SSC_SC_GLOBAL    3'h2
`define SSC_SC_SAVE      3'h3
`define SSC_SC_CENTRAL   3'h4
`define SSC_SC_PARITY    3'h5
`define SSC_SC_TBG       3'h6
`define SSC_SC_PROTECT   3'h7
`define SSC_OFS_STATE    8'h00
`define SSC_OFS_PERR     8'h04
`define SSC_OFS_VIOL     8'h08
`define SSC_OFS_BOOTPTR  8'h0c
`define SSC_OFS_GLOBAL   8'h10
`define SSC_RST_WORD     16'h0000
`define SSC_RST_PERR     24'h000000
`define SSC_TBG_PERIOD_NS 10000000
`define SSC_CLK_PERIOD_NS 20
`define SSC_RESP_OKAY    2'h0
`define SSC_RESP_SLVERR  2'h2
`endif

// file: shared/ssc_pkg.sv
// types for the system select code control block
package ssc_pkg;
  typedef enum logic [3:0] {
    SSC_OP_NONE    = 4'h0,
    SSC_OP_SETFLAG = 4'h1,
    SSC_OP_CLRFLAG = 4'h2,
    SSC_OP_SKIPSET = 4'h3,
    SSC_OP_SKIPCLR = 4'h4,
    SSC_OP_MERGE   = 4'h5,
    SSC_OP_LOAD    = 4'h6,
    SSC_OP_OUTPUT  = 4'h7,
    SSC_OP_SETCTL  = 4'h8,
    SSC_OP_CLRCTL  = 4'h9
  } ssc_op_type;
endpackage

// file: rtl/ssc_ctrl.sv
// system select code control: instruction port plus register slave
//
// The AXI4-Lite register port and the address map are this design's own decisions.
`include "ssc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module ssc_ctrl
  import ssc_pkg::*;
#(
  parameter int TbgTicks = `SSC_TBG_PERIOD_NS / `SSC_CLK_PERIOD_NS
) (
  // clock, reset, enable
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        clkEn,
  // instruction port
  input  wire logic        ioValid,
  input  wire ssc_op_type  ioOp,
  input  wire logic [5:0]  ioSelCode,
  input  wire logic        ioClearMod,
  input  wire logic [15:0] ioAccIn,
  output logic             ioDone,
  output logic             ioSkip,
  output logic             ioAccWr,
  output logic [15:0]      ioAccOut,
  // machine sense
  input  wire logic        powerFail,
  // control outputs
  output logic             sysResetReq,
  output logic             class2IntEn,
  output logic             class3IntEn,
  output logic             parityIntEn,
  output logic             parityEven,
  output logic             tbgRun,
  output logic             tbgFlag,
  output logic             memProtectOn,
  output logic             globalRegDis,
  output logic [15:0]      globalReg,
  output logic [2:0]       diagMode,
  output logic             overflow,
  output logic [15:0]      intMaskReg,
  output logic [15:0]      procStatusReg,
  output logic [15:0]      centralIntReg,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  logic [15:0] saveAddr_q;
  logic [15:0] bootPtr_q;
  logic [23:0] parityErr_q;
  logic [15:0] violation_q;
  logic [31:0] tbgCount_q;
  logic        tbgTick;
  logic [7:0]  awAddr_q;
  logic [31:0] wData_q;
  logic [3:0]  wStrb_q;
  logic        awHave_q;
  logic        wHave_q;
  logic        axiWr;
  logic        ins;
  logic        sc0;
  logic        sc1;
  logic        sc2;
  logic        sc3;
  logic        sc4;
  logic        sc5;
  logic        sc6;
  logic        sc7;
  logic        skipNow;
  logic        loadNow;
  logic [15:0] loadVal;
  logic [31:0] readVal;
  logic        readHit;

  function automatic logic [31:0] mergeLanes(input logic [31:0] oldV,
                                             input logic [31:0] newV,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = oldV;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = newV[8*i +: 8];
      end
    end
    return res;
  endfunction

  // instruction decode, only codes 0..7 belong here
  assign ins = ioValid && (ioSelCode[5:3] == 3'h0);
  assign sc0 = ins && (ioSelCode[2:0] == `SSC_SC_MASK);
  assign sc1 = ins && (ioSelCode[2:0] == `SSC_SC_STATUS);
  assign sc2 = ins && (ioSelCode[2:0] == `SSC_SC_GLOBAL);
  assign sc3 = ins && (ioSelCode[2:0] == `SSC_SC_SAVE);
  assign sc4 = ins && (ioSelCode[2:0] == `SSC_SC_CENTRAL);
  assign sc5 = ins && (ioSelCode[2:0] == `SSC_SC_PARITY);
  assign sc6 = ins && (ioSelCode[2:0] == `SSC_SC_TBG);
  assign sc7 = ins && (ioSelCode[2:0] == `SSC_SC_PROTECT);

  // skip and load results from state before this instruction
  always_comb begin
    skipNow = 1'b0;
    loadNow = 1'b0;
    loadVal = 16'h0000;
    case (ioOp)
      SSC_OP_SKIPSET: begin
        if (sc0) skipNow = class3IntEn;
        if (sc1) skipNow = overflow;
        if (sc2) skipNow = globalRegDis;
        if (sc4) skipNow = !powerFail;
        if (sc5) skipNow = parityEven;
        if (sc6) skipNow = tbgFlag;
      end
      SSC_OP_SKIPCLR: begin
        if (sc0) skipNow = !class3IntEn;
        if (sc1) skipNow = !overflow;
        if (sc2) skipNow = !globalRegDis;
        if (sc4) skipNow = powerFail;
        if (sc5) skipNow = !parityEven;
        if (sc6) skipNow = !tbgFlag;
      end
      SSC_OP_MERGE: begin
        if (sc1) begin
          loadNow = 1'b1;
          loadVal = ioAccIn | procStatusReg;
        end
      end
      SSC_OP_LOAD: begin
        loadNow = sc0 || sc1 || sc2 || sc3 || sc4 || sc5 || sc7;
        if (sc0) loadVal = intMaskReg;
        if (sc1) loadVal = procStatusReg;
        if (sc2) loadVal = globalReg;
        if (sc3) loadVal = ioClearMod ? bootPtr_q : saveAddr_q;
        if (sc4) loadVal = centralIntReg;
        if (sc5) begin
          loadVal = ioClearMod ? {8'h00, parityErr_q[23:16]}
                               : parityErr_q[15:0];
        end
        if (sc7) loadVal = violation_q;
      end
      default: begin
        loadNow = 1'b0;
      end
    endcase
  end

  // answer to the execution unit, one cycle after the request
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ioDone   <= 1'b0;
      ioSkip   <= 1'b0;
      ioAccWr  <= 1'b0;
      ioAccOut <= `SSC_RST_WORD;
    end else if (clkEn) begin
      ioDone  <= ins;
      ioSkip  <= skipNow;
      ioAccWr <= loadNow;
      if (loadNow) ioAccOut <= loadVal;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sysResetReq <= 1'b0;
    end else if (clkEn) begin
      sysResetReq <= sc0 && (ioOp == SSC_OP_CLRCTL);
    end
  end

  // interrupt class enables
  always_ff @(posedge core_clk) begin
    if (rst) begin
      class2IntEn <= 1'b0;
      class3IntEn <= 1'b0;
    end else if (clkEn) begin
      if (sc4 && ioOp == SSC_OP_SETCTL) begin
        class2IntEn <= 1'b1;
        class3IntEn <= 1'b1;
      end
      if (sc4 && ioOp == SSC_OP_CLRCTL) begin
        class2IntEn <= 1'b0;
        class3IntEn <= 1'b0;
      end
      if (sc0 && ioOp == SSC_OP_SETFLAG) class3IntEn <= 1'b1;
      if (sc0 && ioOp == SSC_OP_CLRFLAG) class3IntEn <= 1'b0;
    end
  end

  // parity controls
  always_ff @(posedge core_clk) begin
    if (rst) begin
      parityIntEn <= 1'b0;
      parityEven  <= 1'b0;
    end else if (clkEn) begin
      if (sc5 && ioOp == SSC_OP_SETCTL) parityIntEn <= 1'b1;
      if (sc5 && ioOp == SSC_OP_CLRCTL) parityIntEn <= 1'b0;
      if (sc5 && ioOp == SSC_OP_SETFLAG) parityEven <= 1'b1;
      if (sc5 && ioOp == SSC_OP_CLRFLAG) parityEven <= 1'b0;
    end
  end

  // time base generator
  assign tbgTick = tbgRun && (tbgCount_q == 32'(TbgTicks - 1));

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tbgRun     <= 1'b0;
      tbgCount_q <= 32'h00000000;
    end else if (clkEn) begin
      if (sc6 && ioOp == SSC_OP_SETCTL) tbgRun <= 1'b1;
      if (sc6 && ioOp == SSC_OP_CLRCTL) tbgRun <= 1'b0;
      if (!tbgRun || tbgTick) begin
        tbgCount_q <= 32'h00000000;
      end else begin
        tbgCount_q <= tbgCount_q + 32'h00000001;
      end
    end
  end

  // tick wins over a clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tbgFlag <= 1'b0;
    end else if (clkEn) begin
      if (tbgTick || (sc6 && ioOp == SSC_OP_SETFLAG)) begin
        tbgFlag <= 1'b1;
      end else if (sc6 && ioOp == SSC_OP_CLRFLAG) begin
        tbgFlag <= 1'b0;
      end
    end
  end

  // memory protect: only switched on here
  always_ff @(posedge core_clk) begin
    if (rst) begin
      memProtectOn <= 1'b0;
    end else if (clkEn) begin
      if (sc7 && ioOp == SSC_OP_SETCTL) memProtectOn <= 1'b1;
    end
  end

  // global register and diagnose modes
  always_ff @(posedge core_clk) begin
    if (rst) begin
      globalRegDis <= 1'b0;
      globalReg    <= `SSC_RST_WORD;
      diagMode     <= 3'h0;
    end else if (clkEn) begin
      if (sc2 && ioOp == SSC_OP_SETFLAG) globalRegDis <= 1'b1;
      if (sc2 && ioOp == SSC_OP_CLRFLAG) globalRegDis <= 1'b0;
      if (sc2 && ioOp == SSC_OP_OUTPUT) begin
        globalReg <= ioAccIn;
        if (ioAccIn[15:3] == 13'h0000) begin
          diagMode <= ioAccIn[2:0];
        end else begin
          diagMode <= 3'h0;
        end
      end
    end
  end

  // overflow bit
  always_ff @(posedge core_clk) begin
    if (rst) begin
      overflow <= 1'b0;
    end else if (clkEn) begin
      if (sc1 && ioOp == SSC_OP_SETFLAG) overflow <= 1'b1;
      if (sc1 && ioOp == SSC_OP_CLRFLAG) overflow <= 1'b0;
    end
  end

  // word registers written by output instructions
  always_ff @(posedge core_clk) begin
    if (rst) begin
      intMaskReg    <= `SSC_RST_WORD;
      procStatusReg <= `SSC_RST_WORD;
      centralIntReg <= `SSC_RST_WORD;
      saveAddr_q    <= `SSC_RST_WORD;
    end else if (clkEn) begin
      if (sc0 && ioOp == SSC_OP_OUTPUT) intMaskReg <= ioAccIn;
      if (sc1 && ioOp == SSC_OP_OUTPUT) procStatusReg <= ioAccIn;
      if (sc4 && ioOp == SSC_OP_OUTPUT) centralIntReg <= ioAccIn;
      if (sc3 && ioOp == SSC_OP_OUTPUT && !ioClearMod) begin
        saveAddr_q <= ioAccIn;
      end
    end
  end

  // registers shared with the bus; the instruction wins a collision
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bootPtr_q <= `SSC_RST_WORD;
    end else if (clkEn) begin
      if (sc3 && ioOp == SSC_OP_OUTPUT && ioClearMod) begin
        bootPtr_q <= ioAccIn;
      end else if (axiWr && awAddr_q == `SSC_OFS_BOOTPTR) begin
        bootPtr_q <= 16'(mergeLanes({16'h0000, bootPtr_q}, wData_q, wStrb_q));
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      parityErr_q <= `SSC_RST_PERR;
      violation_q <= `SSC_RST_WORD;
    end else if (clkEn) begin
      if (axiWr && awAddr_q == `SSC_OFS_PERR) begin
        parityErr_q <= 24'(mergeLanes({8'h00, parityErr_q}, wData_q, wStrb_q));
      end
      if (axiWr && awAddr_q == `SSC_OFS_VIOL) begin
        violation_q <= 16'(mergeLanes({16'h0000, violation_q}, wData_q, wStrb_q));
      end
    end
  end

  // axi4-lite write channel
  assign axiWr = awHave_q && wHave_q && !s_axi_bvalid;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      awHave_q      <= 1'b0;
      wHave_q       <= 1'b0;
      awAddr_q      <= 8'h00;
      wData_q       <= 32'h00000000;
      wStrb_q       <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SSC_RESP_OKAY;
    end else if (clkEn) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr_q      <= {s_axi_awaddr[7:2], 2'b00};
        awHave_q      <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData_q      <= s_axi_wdata;
        wStrb_q      <= s_axi_wstrb;
        wHave_q      <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (axiWr) begin
        awHave_q     <= 1'b0;
        wHave_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awAddr_q == `SSC_OFS_PERR || awAddr_q == `SSC_OFS_VIOL ||
            awAddr_q == `SSC_OFS_BOOTPTR) begin
          s_axi_bresp <= `SSC_RESP_OKAY;
        end else begin
          s_axi_bresp <= `SSC_RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // axi4-lite read decode
  always_comb begin
    readVal = 32'h00000000;
    readHit = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      `SSC_OFS_STATE: begin
        readVal = {19'h00000, diagMode, overflow, powerFail, tbgRun, tbgFlag,
                   parityEven, parityIntEn, memProtectOn, globalRegDis,
                   class3IntEn, class2IntEn};
      end
      `SSC_OFS_PERR:    readVal = {8'h00, parityErr_q};
      `SSC_OFS_VIOL:    readVal = {16'h0000, violation_q};
      `SSC_OFS_BOOTPTR: readVal = {16'h0000, bootPtr_q};
      `SSC_OFS_GLOBAL:  readVal = {16'h0000, globalReg};
      default:          readHit = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `SSC_RESP_OKAY;
    end else if (clkEn) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= readVal;
        s_axi_rresp   <= readHit ? `SSC_RESP_OKAY : `SSC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// file: verification/ssc_cpu_model.sv
// processor model issuing I/O group instructions
`timescale 1ns/1ps
`default_nettype none
module ssc_cpu_model
  import ssc_pkg::*;
(
  // clock
  input  wire logic        core_clk,
  // instruction port
  output var logic         ioValid,
  output var ssc_op_type   ioOp,
  output var logic [5:0]   ioSelCode,
  output var logic         ioClearMod,
  output var logic [15:0]  ioAccIn,
  input  wire logic        ioDone,
  input  wire logic        ioSkip,
  input  wire logic        ioAccWr,
  input  wire logic [15:0] ioAccOut
);
  logic        done;
  logic        skip;
  logic        accWr;
  logic [15:0] acc;
  initial begin
    ioValid = 1'b0;
    ioOp = SSC_OP_NONE;
    ioSelCode = 6'h00;
    ioClearMod = 1'b0;
    ioAccIn = 16'h0000;
  end
  // one instruction for one cycle; afterwards clear modifier and accumulator lines show inverted values, op and code hold
  task automatic io(input ssc_op_type o, input logic [5:0] sc, input logic cm = 1'b0,
                    input logic [15:0] a = 16'h0000);
    @(posedge core_clk);
    ioValid <= 1'b1;
    ioOp <= o;
    ioSelCode <= sc;
    ioClearMod <= cm;
    ioAccIn <= a;
    @(posedge core_clk);
    ioValid <= 1'b0;
    ioClearMod <= ~cm;
    ioAccIn <= ~a;
    #1;
    done = ioDone;
    skip = ioSkip;
    accWr = ioAccWr;
    acc = ioAccOut;
  endtask
endmodule
`default_nettype wire

// file: verification/ssc_ctrl_assertions.sv
// checker for the instruction port of the select code control block
`timescale 1ns/1ps
`default_nettype none
module ssc_ctrl_chk
  import ssc_pkg::*;
#(
  parameter int TbgTicks = 8
) (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       clkEn,
  input wire logic       ioValid,
  input wire ssc_op_type ioOp,
  input wire logic [5:0] ioSelCode,
  input wire logic [15:0] ioAccIn,
  input wire logic       powerFail,
  input wire logic       ioDone,
  input wire logic       ioSkip,
  input wire logic       sysResetReq,
  input wire logic       class2IntEn,
  input wire logic       class3IntEn,
  input wire logic       parityEven,
  input wire logic       memProtectOn,
  input wire logic [2:0] diagMode
);
  logic        go;
  logic [10:0] key;
  assign go = clkEn && ioValid && (ioSelCode < 6'h08);
  // passed in as an argument so that the sampled request is what gets decoded
  assign key = {go, ioOp, ioSelCode};
  function automatic logic at(input logic [10:0] k, input ssc_op_type o, input logic [5:0] c);
    return k == {1'b1, o, c};
  endfunction
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_done; go |=> ioDone; endproperty
  a_done: assert property (p_done) else $error("no done after request");
  property p_noDone; clkEn && !go |=> !ioDone; endproperty
  a_noDone: assert property (p_noDone) else $error("done without request");
  property p_c23On;
    at(key, SSC_OP_SETCTL, 6'h04) |=> class2IntEn && class3IntEn;
  endproperty
  a_c23On: assert property (p_c23On) else $error("classes not enabled");
  property p_c23Off;
    at(key, SSC_OP_CLRCTL, 6'h04) |=> !class2IntEn && !class3IntEn;
  endproperty
  a_c23Off: assert property (p_c23Off) else $error("classes not disabled");
  property p_skip3;
    at(key, SSC_OP_SKIPSET, 6'h00) |=> ioSkip == $past(class3IntEn);
  endproperty
  a_skip3: assert property (p_skip3) else $error("bad class three skip");
  property p_parity;
    at(key, SSC_OP_SETFLAG, 6'h05) || at(key, SSC_OP_CLRFLAG, 6'h05)
      |=> parityEven == ($past(ioOp) == SSC_OP_SETFLAG);
  endproperty
  a_parity: assert property (p_parity) else $error("bad parity sense");
  property p_power;
    at(key, SSC_OP_SKIPCLR, 6'h04) |=> ioDone && ioSkip == $past(powerFail);
  endproperty
  a_power: assert property (p_power) else $error("bad power skip");
  property p_protect;
    at(key, SSC_OP_CLRCTL, 6'h07) |=> $stable(memProtectOn);
  endproperty
  a_protect: assert property (p_protect) else $error("protect changed");
  property p_diag;
    at(key, SSC_OP_OUTPUT, 6'h02) && ioAccIn inside {[16'h0001:16'h0007]}
      |=> diagMode == $past(ioAccIn[2:0]);
  endproperty
  a_diag: assert property (p_diag) else $error("bad diagnose mode");
  // request follows exactly the cycles that carried a clear-control at code 0
  property p_reset;
    clkEn |=> sysResetReq == at($past(key), SSC_OP_CLRCTL, 6'h00);
  endproperty
  a_reset: assert property (p_reset) else $error("bad reset request");
  c_skip: cover property (go ##1 ioSkip);
  c_reset: cover property (sysResetReq);
  c_diag: cover property (diagMode == 3'h7);
endmodule
bind ssc_ctrl ssc_ctrl_chk #(.TbgTicks(TbgTicks)) u_chk (.core_clk, .rst, .clkEn, .ioValid,
  .ioOp, .ioSelCode, .ioAccIn, .powerFail, .ioDone, .ioSkip, .sysResetReq, .class2IntEn,
  .class3IntEn, .parityEven, .memProtectOn, .diagMode);
`default_nettype wire

// file: verification/ssc_ctrl_test.sv
// bench for the system select code control block
`include "ssc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module ssc_ctrl_test
  import ssc_pkg::*;
();
  localparam int TbgTicks = 8;
  logic        core_clk = 1'b0, rst = 1'b1, clkEn = 1'b1, powerFail = 1'b0;
  logic        ioValid, ioClearMod, ioDone, ioSkip, ioAccWr, sysResetReq, overflow;
  logic        class2IntEn, class3IntEn, parityIntEn, parityEven, tbgRun, tbgFlag;
  logic        memProtectOn, globalRegDis;
  ssc_op_type  ioOp;
  logic [5:0]  ioSelCode;
  logic [2:0]  diagMode;
  logic [15:0] ioAccIn, ioAccOut, globalReg, intMaskReg, procStatusReg, centralIntReg;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  int          err_count = 0, n_tests = 0, cycles = 0;
  ssc_ctrl #(.TbgTicks(TbgTicks)) dut (.*);
  ssc_cpu_model cpu (.*);
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 6000) begin
      err_count++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic axiWr(input logic [7:0] ad, input logic [31:0] v, output logic [1:0] rs);
    bit a = 1'b1, w = 1'b1;
    @(posedge core_clk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (a || w) begin
      @(posedge core_clk);
      if (a && s_axi_awready) begin
        a = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axiRd(input logic [7:0] ad, output logic [31:0] v, output logic [1:0] rs);
    @(posedge core_clk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  function automatic logic [31:0] ctlV();
    return {27'h0, class2IntEn, class3IntEn, parityIntEn, tbgRun, memProtectOn};
  endfunction
  function automatic logic flagOf(input int c);
    case (c)
      0: return class3IntEn;
      5: return parityEven;
      6: return tbgFlag;
      2: return globalRegDis;
      default: return overflow;
    endcase
  endfunction
  task automatic t_ctl();
    logic [4:0] up[4] = '{5'h18, 5'h1c, 5'h1e, 5'h1f};
    logic [4:0] dn[4] = '{5'h07, 5'h03, 5'h01, 5'h01};
    chk("reset state", 32'h0, ctlV());
    for (int i = 0; i < 4; i++) begin
      cpu.io(SSC_OP_SETCTL, 6'(4 + i));
      chk("ctl set", 32'(up[i]), ctlV());
    end
    for (int i = 0; i < 4; i++) begin
      cpu.io(SSC_OP_CLRCTL, 6'(4 + i));
      chk("ctl clear", 32'(dn[i]), ctlV());
    end
  endtask
  task automatic t_tbg();
    cpu.io(SSC_OP_SETCTL, 6'h06);
    cpu.io(SSC_OP_CLRFLAG, 6'h06);
    repeat (TbgTicks + 2) @(posedge core_clk);
    chk("tbg tick", 32'h1, 32'(tbgFlag));
    cpu.io(SSC_OP_CLRCTL, 6'h06);
    cpu.io(SSC_OP_CLRFLAG, 6'h06);
    repeat (2 * TbgTicks) @(posedge core_clk);
    chk("tbg stopped", 32'h0, 32'(tbgFlag));
  endtask
  task automatic t_flags();
    int c[5] = '{0, 5, 6, 2, 1};
    for (int i = 0; i < 5; i++) begin
      for (int s = 1; s >= 0; s--) begin
        cpu.io(s ? SSC_OP_SETFLAG : SSC_OP_CLRFLAG, 6'(c[i]));
        chk("flag", 32'(s), 32'(flagOf(c[i])));
        cpu.io(SSC_OP_SKIPSET, 6'(c[i]));
        chk("skip set", 32'(s), 32'(cpu.skip));
        cpu.io(SSC_OP_SKIPCLR, 6'(c[i]));
        chk("skip clr", 32'(1 - s), 32'(cpu.skip));
      end
    end
    for (int p = 0; p < 2; p++) begin
      @(posedge core_clk);
      powerFail <= 1'(p);
      cpu.io(SSC_OP_SKIPSET, 6'h04);
      chk("power set", 32'(1 - p), 32'(cpu.skip));
      cpu.io(SSC_OP_SKIPCLR, 6'h04);
      chk("power clr", 32'(p), 32'(cpu.skip));
    end
  endtask
  task automatic t_regs();
    logic [5:0] sc[4] = '{6'h00, 6'h01, 6'h02, 6'h04};
    for (int i = 0; i < 4; i++) begin
      cpu.io(SSC_OP_OUTPUT, sc[i], 1'b0, 16'h5a00 + 16'(sc[i]));
      cpu.io(SSC_OP_LOAD, sc[i]);
      chk("load", 32'h15a00 + 32'(sc[i]), {15'h0, cpu.accWr, cpu.acc});
    end
    chk("mask", 32'h5a00, 32'(intMaskReg));
    chk("status", 32'h5a01, 32'(procStatusReg));
    chk("global", 32'h5a02, 32'(globalReg));
    chk("central", 32'h5a04, 32'(centralIntReg));
    cpu.io(SSC_OP_MERGE, 6'h01, 1'b0, 16'h00f0);
    chk("merge", 32'h5af1, 32'(cpu.acc));
    cpu.io(SSC_OP_OUTPUT, 6'h03, 1'b0, 16'h1111);
    cpu.io(SSC_OP_OUTPUT, 6'h03, 1'b1, 16'h2222);
    cpu.io(SSC_OP_LOAD, 6'h03);
    chk("saved addr", 32'h1111, 32'(cpu.acc));
    cpu.io(SSC_OP_LOAD, 6'h03, 1'b1);
    chk("boot ptr", 32'h2222, 32'(cpu.acc));
    for (int v = 0; v < 9; v++) begin
      cpu.io(SSC_OP_OUTPUT, 6'h02, 1'b0, 16'(v));
      chk("diag", (v >= 1 && v <= 7) ? 32'(v) : 32'h0, 32'(diagMode));
    end
  endtask
  task automatic t_bus();
    axiWr(`SSC_OFS_PERR, 32'h00abcdef, r);
    chk("perr bresp", 32'(`SSC_RESP_OKAY), 32'(r));
    cpu.io(SSC_OP_LOAD, 6'h05);
    chk("parity lo", 32'hcdef, 32'(cpu.acc));
    cpu.io(SSC_OP_LOAD, 6'h05, 1'b1);
    chk("parity hi", 32'h00ab, 32'(cpu.acc));
    axiWr(`SSC_OFS_VIOL, 32'h00001357, r);
    cpu.io(SSC_OP_LOAD, 6'h07);
    chk("violation", 32'h1357, 32'(cpu.acc));
    s_axi_wstrb <= 4'h1;
    axiWr(`SSC_OFS_VIOL, 32'h0000ffaa, r);
    s_axi_wstrb <= 4'hf;
    cpu.io(SSC_OP_LOAD, 6'h07);
    chk("violation lane", 32'h13aa, 32'(cpu.acc));
    axiWr(`SSC_OFS_BOOTPTR, 32'h00004321, r);
    cpu.io(SSC_OP_LOAD, 6'h03, 1'b1);
    chk("bus boot ptr", 32'h4321, 32'(cpu.acc));
    axiRd(`SSC_OFS_GLOBAL, d, r);
    chk("global read", 32'h8, d);
    chk("global rresp", 32'(`SSC_RESP_OKAY), 32'(r));
    axiWr(`SSC_OFS_STATE, 32'hffffffff, r);
    chk("ro bresp", 32'(`SSC_RESP_SLVERR), 32'(r));
    axiRd(8'h40, d, r);
    chk("unmapped data", 32'h0, d);
    chk("unmapped resp", 32'(`SSC_RESP_SLVERR), 32'(r));
    axiRd(`SSC_OFS_STATE, d, r);
    chk("state", 32'h108, d);
  endtask
  task automatic t_misc();
    cpu.io(SSC_OP_SETCTL, 6'h08);
    chk("code 8", 32'h0, 32'(cpu.done));
    cpu.io(SSC_OP_MERGE, 6'h00);
    chk("nop", 32'h2, {30'h0, cpu.done, cpu.accWr});
    cpu.io(SSC_OP_CLRCTL, 6'h00);
    chk("sys reset", 32'h1, 32'(sysResetReq));
    // an instruction offered while the enable is low must be lost
    @(posedge core_clk);
    clkEn <= 1'b0;
    cpu.io(SSC_OP_SETFLAG, 6'h01);
    chk("frozen done", 32'h0, 32'(cpu.done));
    chk("frozen flag", 32'h0, 32'(overflow));
    @(posedge core_clk);
    clkEn <= 1'b1;
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    t_ctl();
    t_tbg();
    t_flags();
    t_regs();
    t_bus();
    t_misc();
    results();
  end
endmodule
`default_nettype wire
